//--- rtl/flash_dev.sv
// serial flash device end: bit engine, busy timing, power-down and protection

module flash_dev
	import flash_link_pkg::*;
#(
	parameter int unsigned LOCK_CYC = T_LOCK_US * CLK_MHZ,
	parameter int unsigned XUDPD_CYC = T_XUDPD_US * CLK_MHZ,
	parameter int unsigned XFR_CYC = T_XFR_US * CLK_MHZ,
	parameter int unsigned COMP_CYC = T_COMP_US * CLK_MHZ,
	parameter int unsigned EP_CYC = T_EP_TYP_MS * US_PER_MS * CLK_MHZ,
	parameter int unsigned OTP_CYC = T_OTP_TYP_US * CLK_MHZ
) (
	// clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// serial link
	flash_link_if.dev_mp link,
	// user side
	input wire logic [7:0] i_tx_data,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	output logic o_busy,
	output logic o_pdown,
	output logic o_protected,
	output logic o_frozen
);

	////////////////////////////////////////////////////////////////////////////
	// state

	// timer loads trimmed by the synchroniser delay so the pin-level time holds
	localparam tmr_t LOCK_T = tmr_t'(LOCK_CYC - SYNC_LAT - 1);
	localparam tmr_t XUDPD_T = tmr_t'(XUDPD_CYC - SYNC_LAT - 1);
	localparam tmr_t XFR_T = tmr_t'(XFR_CYC - SYNC_LAT - 1);
	localparam tmr_t COMP_T = tmr_t'(COMP_CYC - SYNC_LAT - 1);
	localparam tmr_t EP_T = tmr_t'(EP_CYC - SYNC_LAT - 1);
	localparam tmr_t OTP_T = tmr_t'(OTP_CYC - SYNC_LAT - 1);
	localparam tmr_t RDPD_T = tmr_t'(RDPD_CYC - SYNC_LAT - 1);
	localparam logic [5:0] WP_END = 6'(WP_CYC - SYNC_LAT - 1);
	localparam logic [1:0] BYTE_SAT = 2'h2;

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic sck_q;
		logic cs_q;
		logic mosi_q;
		dev_state_e st;
		tmr_t tmr;
		logic lock_pend;
		logic [2:0] bitcnt;
		logic [1:0] bytecnt;
		logic [7:0] rx_sh;
		logic [7:0] opcode;
		logic [7:0] tx_sh;
		logic [7:0] rx_data;
		logic rx_valid;
		logic miso;
		logic miso_oe_n;
		logic prot;
		logic [5:0] wp_cnt;
		logic frozen;
		logic busy;
		logic pdown;
	} dev_s;

	localparam dev_s DEV_RST = '{
		s1: PIN_IDLE,
		s2: PIN_IDLE,
		cs_q: 1'h1,
		miso_oe_n: 1'h1,
		st: D_READY,
		default: '0
	};

	dev_s r;
	dev_s next_r;
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;
	logic rd_op;

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_r = r;
		next_r.s1 = {link.wp_n, link.mosi, link.cs_n, link.sck};
		next_r.s2 = r.s1;
		next_r.sck_q = r.s2[PIN_SCK];
		next_r.cs_q = r.s2[PIN_CS];
		// mosi moves together with the rise, so the bit is the copy one cycle older
		next_r.mosi_q = r.s2[PIN_MOSI];
		next_r.rx_valid = 1'h0;
		sck_rise = r.s2[PIN_SCK] & ~r.sck_q;
		sck_fall = ~r.s2[PIN_SCK] & r.sck_q;
		cs_fall = r.cs_q & ~r.s2[PIN_CS];
		cs_rise = ~r.cs_q & r.s2[PIN_CS];
		rd_op = 1'h0;

		// protection tracks the inverted pin after a settle count
		if (r.s2[PIN_WP] == r.prot) begin
			if (r.wp_cnt == WP_END) begin
				next_r.prot = ~r.prot;
				next_r.wp_cnt = '0;
			end else begin
				next_r.wp_cnt = r.wp_cnt + 6'h1;
			end
		end else begin
			next_r.wp_cnt = '0;
		end

		// output is driven only while selected, whatever the sck idle level
		next_r.miso_oe_n = r.s2[PIN_CS];

		if (cs_fall) begin
			next_r.bitcnt = '0;
			next_r.bytecnt = '0;
			next_r.opcode = '0;
			next_r.tx_sh = '0;
			// any low pulse on select wakes from ultra-deep sleep
			if (r.st == D_UDPD) begin
				next_r.st = D_BUSY;
				next_r.tmr = XUDPD_T;
			end
		end else if (!r.s2[PIN_CS] && r.st != D_UDPD) begin
			// input sampled before the host's next launch reaches us
			if (sck_rise) begin
				next_r.rx_sh = {r.rx_sh[6:0], r.mosi_q};
				next_r.bitcnt = r.bitcnt + 3'h1;
				if (r.bitcnt == BIT_LAST) begin
					next_r.rx_data = next_r.rx_sh;
					next_r.rx_valid = 1'h1;
					if (r.bytecnt == '0) begin
						next_r.opcode = next_r.rx_sh;
					end
					if (r.bytecnt != BYTE_SAT) begin
						next_r.bytecnt = r.bytecnt + 2'h1;
					end
					rd_op = (next_r.opcode == OP_RD_FAST) || (next_r.opcode == OP_RD_SLOW)
						|| (next_r.opcode == OP_RD_HIGH);
					next_r.tx_sh = '0;
					if (next_r.opcode == OP_STATUS) begin
						next_r.tx_sh[ST_READY] = (r.st == D_READY);
						next_r.tx_sh[ST_PROT] = r.prot;
						next_r.tx_sh[ST_FROZEN] = r.frozen;
					end else if (rd_op && r.st == D_READY) begin
						// array data only when idle
						next_r.tx_sh = i_tx_data;
					end
				end
			end
			// launched a few cycles after the fall, well inside the low phase
			if (sck_fall) begin
				next_r.miso = r.tx_sh[7];
				next_r.tx_sh = {r.tx_sh[6:0], 1'h0};
			end
		end

		// busy countdown
		if (r.st == D_BUSY) begin
			if (r.tmr == '0) begin
				next_r.st = D_READY;
				if (r.lock_pend) begin
					next_r.frozen = 1'h1;
				end
				next_r.lock_pend = 1'h0;
			end else begin
				next_r.tmr = r.tmr - tmr_t'(1);
			end
		end

		// commands act when select rises after a whole opcode
		if (cs_rise && r.bytecnt != '0) begin
			case (r.st)
				D_READY: begin
					case (r.opcode)
						OP_XFER: begin
							next_r.st = D_BUSY;
							next_r.tmr = XFR_T;
						end
						OP_COMPARE: begin
							next_r.st = D_BUSY;
							next_r.tmr = COMP_T;
						end
						OP_ERASE_PROG: begin
							// a protected array refuses the write
							if (!r.prot) begin
								next_r.st = D_BUSY;
								next_r.tmr = EP_T;
							end
						end
						OP_OTP_PROG: begin
							next_r.st = D_BUSY;
							next_r.tmr = OTP_T;
						end
						OP_LOCK: begin
							if (!r.frozen) begin
								next_r.st = D_BUSY;
								next_r.tmr = LOCK_T;
								next_r.lock_pend = 1'h1;
							end
						end
						// entry is immediate, inside both entry limits
						OP_DPD: begin
							next_r.st = D_DPD;
						end
						OP_UDPD: begin
							next_r.st = D_UDPD;
						end
						default: begin
						end
					endcase
				end
				D_DPD: begin
					if (r.opcode == OP_RESUME) begin
						next_r.st = D_BUSY;
						next_r.tmr = RDPD_T;
					end
				end
				default: begin
				end
			endcase
		end

		next_r.busy = (next_r.st == D_BUSY);
		next_r.pdown = (next_r.st == D_DPD) || (next_r.st == D_UDPD);
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			r <= DEV_RST;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	assign link.miso = r.miso;
	assign link.miso_oe_n = r.miso_oe_n;
	assign o_rx_data = r.rx_data;
	assign o_rx_valid = r.rx_valid;
	assign o_busy = r.busy;
	assign o_pdown = r.pdown;
	assign o_protected = r.prot;
	assign o_frozen = r.frozen;

endmodule // flash_dev

//--- rtl/flash_host.sv
// serial flash host end with its command byte fifo

module link_fifo #(
	parameter int W = 9,
	parameter int D = 4
) (
	// clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	// drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	// depth must be a power of two so the pointers wrap on their own
	localparam int AW = $clog2(D);
	localparam logic [AW:0] CNT_FULL = (AW+1)'(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
		logic in_ready;
		logic out_valid;
	} fifo_s;

	fifo_s r;
	fifo_s next_r;
	logic push;
	logic pop;

	always_comb begin
		next_r = r;
		push = i_in_valid & r.in_ready;
		pop = r.out_valid & i_out_ready;
		if (push) begin
			next_r.mem[r.wr] = i_in_data;
			next_r.wr = r.wr + AW'(1);
		end
		if (pop) begin
			next_r.rd = r.rd + AW'(1);
		end
		if (push && !pop) begin
			next_r.cnt = r.cnt + (AW+1)'(1);
		end else if (pop && !push) begin
			next_r.cnt = r.cnt - (AW+1)'(1);
		end
		next_r.in_ready = (next_r.cnt != CNT_FULL);
		next_r.out_valid = (next_r.cnt != '0);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			r <= '0;
			r.in_ready <= 1'h1;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	assign o_in_ready = r.in_ready;
	assign o_out_valid = r.out_valid;
	assign o_out_data = r.mem[r.rd];

endmodule // link_fifo

////////////////////////////////////////////////////////////////////////////////

module flash_host
	import flash_link_pkg::*;
(
	// clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// serial link
	flash_link_if.host_mp link,
	// command bytes in
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_last,
	output logic o_tx_ready,
	// answer bytes out
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	// control and status
	input wire logic i_mode3,
	input wire logic i_wake,
	input wire logic i_wp_n,
	output logic o_busy
);
	localparam logic [2:0] HALF_END = 3'(SCK_HALF - 1);
	localparam logic [4:0] CS_HOLD_END = 5'(CS_HIGH_CYC);
	localparam logic [4:0] CSLU_END = 5'(CSLU_CYC - 1);

	typedef struct packed {
		logic s1;
		logic s2;
		host_state_e st;
		logic [2:0] div;
		logic sck;
		logic cs_n;
		logic mosi;
		logic wp_n;
		logic [7:0] tx;
		logic [2:0] txbit;
		logic last;
		logic done;
		logic seen_rise;
		logic [7:0] rx;
		logic [2:0] rxbit;
		logic [7:0] rx_data;
		logic rx_valid;
		logic [4:0] hold;
		logic busy;
	} host_s;

	localparam host_s HOST_RST = '{
		s1: 1'h1,
		s2: 1'h1,
		st: H_IDLE,
		cs_n: 1'h1,
		wp_n: 1'h1,
		default: '0
	};

	host_s r;
	host_s next_r;
	logic f_valid;
	logic f_pop;
	logic [FIFO_W-1:0] f_data;

	// draining stalls the sck, so a slow producer only stretches the frame
	link_fifo #(
		.W(FIFO_W),
		.D(FIFO_D)
	) u_fifo (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_in_valid(i_tx_valid),
		.o_in_ready(o_tx_ready),
		.i_in_data({i_tx_last, i_tx_data}),
		.o_out_valid(f_valid),
		.i_out_ready(f_pop),
		.o_out_data(f_data)
	);

	always_comb begin
		next_r = r;
		f_pop = 1'h0;
		next_r.s1 = link.miso_line;
		next_r.s2 = r.s1;
		next_r.rx_valid = 1'h0;
		next_r.wp_n = i_wp_n;
		case (r.st)
			H_IDLE: begin
				next_r.cs_n = 1'h1;
				next_r.sck = i_mode3;
				if (i_wake) begin
					next_r.st = H_WAKE;
					next_r.cs_n = 1'h0;
					next_r.hold = '0;
				end else if (f_valid) begin
					f_pop = 1'h1;
					next_r.tx = f_data[7:0];
					next_r.last = f_data[8];
					next_r.mosi = f_data[7];
					next_r.txbit = '0;
					next_r.rxbit = '0;
					next_r.div = '0;
					next_r.done = 1'h0;
					next_r.seen_rise = 1'h0;
					next_r.cs_n = 1'h0;
					next_r.st = H_RUN;
				end
			end
			H_RUN: begin
				// fixed divider keeps sck far below every read ceiling
				if (r.div != HALF_END) begin
					next_r.div = r.div + 3'h1;
				end else if (!r.sck) begin
					if (!(r.txbit == BIT_LAST && !r.last && !f_valid)) begin
						next_r.div = '0;
						next_r.sck = 1'h1;
						next_r.seen_rise = 1'h1;
						next_r.txbit = r.txbit + 3'h1;
						if (r.txbit != BIT_LAST) begin
							next_r.mosi = r.tx[6];
							next_r.tx = {r.tx[6:0], 1'h0};
						end else if (r.last) begin
							next_r.done = 1'h1;
						end else begin
							f_pop = 1'h1;
							next_r.tx = f_data[7:0];
							next_r.last = f_data[8];
							next_r.mosi = f_data[7];
						end
					end
				end else begin
					next_r.div = '0;
					next_r.sck = 1'h0;
					// the leading fall of an idle-high clock carries no data
					if (r.seen_rise) begin
						next_r.rx = {r.rx[6:0], r.s2};
						next_r.rxbit = r.rxbit + 3'h1;
						if (r.rxbit == BIT_LAST) begin
							next_r.rx_data = next_r.rx;
							next_r.rx_valid = 1'h1;
						end
						if (r.done) begin
							next_r.st = H_END;
							next_r.hold = '0;
						end
					end
				end
			end
			H_END: begin
				next_r.cs_n = 1'h1;
				// sck returns to idle one cycle after select rises
				if (r.hold != '0) begin
					next_r.sck = i_mode3;
				end
				if (r.hold == CS_HOLD_END) begin
					next_r.st = H_IDLE;
				end else begin
					next_r.hold = r.hold + 5'h1;
				end
			end
			H_WAKE: begin
				if (r.hold == CSLU_END) begin
					next_r.st = H_END;
					next_r.hold = '0;
				end else begin
					next_r.hold = r.hold + 5'h1;
				end
			end
			default: begin
				next_r.st = H_IDLE;
			end
		endcase
		next_r.busy = (next_r.st != H_IDLE);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			r <= HOST_RST;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	assign link.sck = r.sck;
	assign link.cs_n = r.cs_n;
	assign link.mosi = r.mosi;
	assign link.wp_n = r.wp_n;
	assign o_rx_data = r.rx_data;
	assign o_rx_valid = r.rx_valid;
	assign o_busy = r.busy;

endmodule // flash_host

//--- rtl/flash_link_if.sv
// serial flash link between the host end and the device end
interface flash_link_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic wp_n;
	logic miso;
	logic miso_oe_n;
	logic miso_line;

	// undriven serial output floats high on the board
	assign miso_line = miso_oe_n ? 1'h1 : miso;

	modport host_mp (output sck, output cs_n, output mosi, output wp_n, input miso_line);
	modport dev_mp (input sck, input cs_n, input mosi, input wp_n, output miso, output miso_oe_n);
endinterface

//--- rtl/flash_link_pkg.sv
// shared constants, opcodes and state types for the serial flash link
package flash_link_pkg;

	// system clock
	localparam int CLK_MHZ = 50;
	localparam int CLK_NS = 20;
	// cycles from a pin edge to the logic that reacts to it
	localparam int SYNC_LAT = 3;

	// pin vector layout inside the device synchroniser
	localparam int PIN_SCK = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_MOSI = 2;
	localparam int PIN_WP = 3;
	localparam logic [3:0] PIN_IDLE = 4'hA;

	// link timing limits
	localparam int T_CS_HIGH_NS = 20;
	localparam int T_CSLU_NS = 20;
	localparam int T_WP_US = 1;
	localparam int T_LOCK_US = 100;
	localparam int T_EUDPD_US = 4;
	localparam int T_XUDPD_US = 180;
	localparam int T_EDPD_US = 2;
	localparam int T_RDPD_US = 35;
	localparam int T_XFR_US = 200;
	localparam int T_COMP_US = 200;
	localparam int T_EP_TYP_MS = 17;
	localparam int T_EP_MAX_MS = 25;
	localparam int T_OTP_TYP_US = 200;
	localparam int T_OTP_MAX_US = 500;
	localparam int US_PER_MS = 1000;

	// least times round up, longest times round down
	localparam int CS_HIGH_CYC = (T_CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int CSLU_CYC = (T_CSLU_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC = T_WP_US * CLK_MHZ;
	localparam int RDPD_CYC = T_RDPD_US * CLK_MHZ;

	// sck ceilings per read command, and the generated rate
	localparam int F_CAR_FAST_MHZ = 85;
	localparam int F_CAR_SLOW_MHZ = 50;
	localparam int F_CAR_HIGH_MHZ = 104;
	localparam int SCK_HALF = 4;
	localparam int SCK_MHZ = CLK_MHZ / (2 * SCK_HALF);

	// opcodes
	localparam logic [7:0] OP_RD_FAST = 8'h0B;
	localparam logic [7:0] OP_RD_SLOW = 8'h03;
	localparam logic [7:0] OP_RD_HIGH = 8'h1B;
	localparam logic [7:0] OP_STATUS = 8'hD7;
	localparam logic [7:0] OP_XFER = 8'h53;
	localparam logic [7:0] OP_COMPARE = 8'h60;
	localparam logic [7:0] OP_ERASE_PROG = 8'h83;
	localparam logic [7:0] OP_OTP_PROG = 8'h9B;
	localparam logic [7:0] OP_LOCK = 8'h7F;
	localparam logic [7:0] OP_DPD = 8'hB9;
	localparam logic [7:0] OP_RESUME = 8'hAB;
	localparam logic [7:0] OP_UDPD = 8'h79;

	// status byte fields
	localparam int ST_READY = 7;
	localparam int ST_PROT = 6;
	localparam int ST_FROZEN = 5;

	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int TMR_W = 21;
	typedef logic [TMR_W-1:0] tmr_t;

	localparam int FIFO_W = 9;
	localparam int FIFO_D = 4;

	typedef enum logic [1:0] {D_READY, D_BUSY, D_DPD, D_UDPD} dev_state_e;
	typedef enum logic [1:0] {H_IDLE, H_RUN, H_END, H_WAKE} host_state_e;

endpackage

//--- test/flash_link_sva.sv
// concurrent checks on the serial flash link wires
module flash_link_sva (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// link wires
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic wp_n,
	input wire logic miso,
	input wire logic miso_oe_n,
	input wire logic miso_line
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	////////////////////////////////////////////////////////////////////////////////
	// rises inside a frame, modulo one byte
	logic [2:0] rises;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || cs_n) begin
			rises <= 3'h0;
		end else if ($rose(sck)) begin
			rises <= rises + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	a_mosi_on_rise: assert property ($changed(mosi) && !$fell(cs_n) |-> $rose(sck))
		else $error("mosi moved away from a rising sck");
	// the pin chain is three flops deep, so the fall shows three cycles late
	a_miso_on_fall: assert property (
		$changed(miso) && !miso_oe_n |-> !$past(sck, 3) && $past(sck, 4))
		else $error("miso moved away from a falling sck");
	a_mosi_held: assert property ($rose(sck) && !cs_n |=> $stable(mosi) [*7])
		else $error("mosi not held for a full sck period");
	a_sck_high: assert property ($rose(sck) && !cs_n |-> sck [*4] ##1 !sck)
		else $error("sck high phase not four cycles");
	a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*2])
		else $error("chip select high time too short");
	a_oe_follows_cs: assert property (miso_oe_n == $past(cs_n, 3))
		else $error("output enable does not follow chip select");
	a_first_edge: assert property ($fell(cs_n) |-> $stable(sck) [*4])
		else $error("sck left its idle level too early");
	a_whole_bytes: assert property ($rose(cs_n) |-> rises == 3'h0)
		else $error("frame ended on a partial byte");

	c_mode0: cover property ($fell(cs_n) && !sck);
	c_mode3: cover property ($fell(cs_n) && sck);
	c_stall: cover property ((!cs_n && !sck) [*6]);
	c_released: cover property ($rose(miso_oe_n) ##1 miso_line);
	c_protect: cover property ($fell(wp_n));
endmodule // flash_link_sva

//--- test/tb_top.sv
// bench for the serial flash link: host and device ends joined by the link interface
module tb_top
	import flash_link_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// shortened busy counts, each above the sync latency
	localparam int LOCK_C = 60;
	localparam int XUD_C = 80;
	localparam int XFR_C = 70;
	localparam int CMP_C = 70;
	localparam int EP_C = 200;
	localparam int OTP_C = 90;

	logic clk;
	logic rst;
	logic tx_valid;
	logic [7:0] tx_data;
	logic tx_last;
	logic mode3;
	logic wake;
	logic wp_n;
	logic [7:0] dev_tx;
	logic h_ready;
	logic [7:0] h_rx;
	logic h_rxv;
	logic h_busy;
	logic [7:0] d_rx;
	logic d_rxv;
	int d_cnt;
	logic d_busy;
	logic d_pdown;
	logic d_prot;
	logic d_frozen;
	logic seen_full;
	logic [7:0] rxq [$];
	int errors;
	int n_compared;
	int cyc;
	logic [7:0] rd_op [4] = '{OP_STATUS, OP_RD_FAST, OP_RD_SLOW, OP_RD_HIGH};
	logic [7:0] t_op [5] = '{OP_XFER, OP_COMPARE, OP_ERASE_PROG, OP_OTP_PROG, OP_LOCK};
	int t_cyc [5] = '{XFR_C, CMP_C, EP_C, OTP_C, LOCK_C};

	////////////////////////////////////////////////////////////////////////////////
	flash_link_if i_flash_link_if ();
	flash_host i_flash_host (.i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1),
		.link(i_flash_link_if.host_mp), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
		.i_tx_last(tx_last), .o_tx_ready(h_ready), .o_rx_data(h_rx), .o_rx_valid(h_rxv),
		.i_mode3(mode3), .i_wake(wake), .i_wp_n(wp_n), .o_busy(h_busy));
	flash_dev #(.LOCK_CYC(LOCK_C), .XUDPD_CYC(XUD_C), .XFR_CYC(XFR_C), .COMP_CYC(CMP_C),
		.EP_CYC(EP_C), .OTP_CYC(OTP_C)) i_flash_dev (.i_sys_clk(clk), .i_rst(rst),
		.i_ce(1'b1), .link(i_flash_link_if.dev_mp), .i_tx_data(dev_tx), .o_rx_data(d_rx),
		.o_rx_valid(d_rxv), .o_busy(d_busy), .o_pdown(d_pdown), .o_protected(d_prot),
		.o_frozen(d_frozen));
	flash_link_sva i_flash_link_sva (.i_sys_clk(clk), .i_rst(rst),
		.sck(i_flash_link_if.sck), .cs_n(i_flash_link_if.cs_n), .mosi(i_flash_link_if.mosi),
		.wp_n(i_flash_link_if.wp_n), .miso(i_flash_link_if.miso),
		.miso_oe_n(i_flash_link_if.miso_oe_n), .miso_line(i_flash_link_if.miso_line));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// collects answer bytes; the ceiling is several times the expected run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (h_rxv === 1'b1) rxq.push_back(h_rx);
		if (d_rxv === 1'b1) d_cnt = d_cnt + 1;
		if (h_ready === 1'b0) seen_full <= 1'b1;
		if (cyc == 20000) begin
			errors = errors + 1;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("compared %0d mismatched %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic flag(input logic seen, input logic exp);
		check({7'h0, seen}, {7'h0, exp});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		tick(12);
		rst <= 1'b0;
		tick(1);
	endtask

	// one frame through the fifo; a gap holds back the last byte, and sck stalls only if the gap outlasts the bytes already queued
	task automatic xfer(input logic [7:0] q[$], input int gap);
		int k;
		rxq.delete();
		d_cnt = 0;
		for (int i = 0; i < q.size(); i++) begin
			if (i == q.size() - 1 && gap > 0) begin
				tx_valid <= 1'b0;
				tick(gap);
			end
			tx_valid <= 1'b1;
			tx_data <= q[i];
			tx_last <= (i == q.size() - 1);
			@(posedge clk);
			while (h_ready !== 1'b1) @(posedge clk);
		end
		tx_valid <= 1'b0;
		tx_last <= 1'b0;
		k = 0;
		tick(3);
		while (h_busy !== 1'b0 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		tick(4);
		check(8'(rxq.size()), 8'(q.size()));
		check(8'(d_cnt), 8'(q.size()));
	endtask

	task automatic busy_within(input int lim);
		int k;
		k = 0;
		while (d_busy === 1'b1 && k <= lim) begin
			@(posedge clk);
			k++;
		end
		flag(k > 0 && k <= lim, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		tx_last = 1'b0;
		mode3 = 1'b0;
		wake = 1'b0;
		wp_n = 1'b1;
		dev_tx = 8'h00;
		seen_full = 1'b0;
		d_cnt = 0;
		errors = 0;
		n_compared = 0;
		cyc = 0;
		do_reset();
		// status and each read command, sck idling low and high in turn
		for (int i = 0; i < 4; i++) begin
			mode3 <= i[0];
			dev_tx <= 8'h5A + 8'(i);
			tick(2);
			xfer({rd_op[i], 8'h00, 8'hC3}, (i == 3) ? 100 : 0);
			check(rxq[1], (i == 0) ? 8'h80 : dev_tx);
			check(rxq[2], (i == 0) ? 8'h80 : dev_tx);
			check(d_rx, 8'hC3);
		end
		// timed operations: busy at once, ready within the count
		for (int i = 0; i < 5; i++) begin
			xfer({t_op[i], 8'h00}, 0);
			flag(d_busy, 1'b1);
			busy_within(t_cyc[i]);
			xfer({OP_STATUS, 8'h00}, 0);
			check(rxq[1], (i == 4) ? 8'hA0 : 8'h80);
		end
		flag(d_frozen, 1'b1);
		xfer({OP_LOCK}, 0);
		flag(d_busy, 1'b0);
		// write protect, with a refused page program in between
		// pin moves one edge after the drive, so this is exactly the pin-level limit
		wp_n <= 1'b0;
		tick(WP_CYC + 1);
		flag(d_prot, 1'b1);
		xfer({OP_ERASE_PROG, 8'h00}, 0);
		flag(d_busy, 1'b0);
		xfer({OP_STATUS, 8'h00}, 0);
		check(rxq[1], 8'hE0);
		wp_n <= 1'b1;
		tick(WP_CYC + 1);
		flag(d_prot, 1'b0);
		// deep sleep, then a read during the resume time answers nothing
		xfer({OP_DPD}, 0);
		flag(d_pdown, 1'b1);
		xfer({OP_RESUME}, 0);
		xfer({OP_RD_FAST, 8'h00}, 0);
		check(rxq[1], 8'h00);
		busy_within(RDPD_CYC);
		flag(d_pdown, 1'b0);
		// ultra-deep sleep left by a short chip select pulse
		xfer({OP_UDPD}, 0);
		flag(d_pdown, 1'b1);
		wake <= 1'b1;
		tick(1);
		wake <= 1'b0;
		tick(8);
		busy_within(XUD_C);
		xfer({OP_STATUS, 8'h00}, 0);
		check(rxq[1], 8'hA0);
		// a long frame fills the fifo until it refuses
		seen_full <= 1'b0;
		xfer({OP_STATUS, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
		flag(seen_full, 1'b1);
		check(rxq[6], 8'hA0);
		// reset in mid-run clears the frozen state
		do_reset();
		flag(d_frozen, 1'b0);
		xfer({OP_STATUS, 8'h00}, 0);
		check(rxq[1], 8'h80);
		close_out();
	end
endmodule // tb_top
